// ---- core/edge_counter.sv ----
// Edge counter on one synchronised digital input.
// Assumes the pin is asynchronous and mode writes are one-cycle strobes.
module edge_counter (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic pin_i,
   input wire logic mode_we_i,
   input wire logic [pid_pkg::MODE_W-1:0] mode_i,
   output logic pin_level_o,
   output logic enabled_o,
   output logic [pid_pkg::COUNT_W-1:0] count_o
);
   logic meta_q, sync_q, prev_q;
   logic [pid_pkg::MODE_W-1:0] mode_q;
   wire rise = sync_q & ~prev_q;
   wire fall = ~sync_q & prev_q;
   wire hit = (mode_q == pid_pkg::MODE_RISE && rise) || (mode_q == pid_pkg::MODE_FALL && fall);
   // Two-stage synchroniser followed by the edge history flop.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   // Mode register and counter; a mode write clears the count.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= pid_pkg::MODE_OFF;
         count_o <= '0;
         enabled_o <= 1'b0;
         pin_level_o <= 1'b0;
      end else begin
         pin_level_o <= sync_q;
         if (mode_we_i) begin
            mode_q <= mode_i;
            enabled_o <= (mode_i == pid_pkg::MODE_RISE) || (mode_i == pid_pkg::MODE_FALL);
            count_o <= '0;
         end else if (hit) begin
            count_o <= count_o + 1'b1;
         end
      end
   end
endmodule

// ---- core/pid_loop_and_pulse_counter.sv ----
// Six PID process loops sharing one arithmetic path, plus the edge counter.
// Assumes converter codes arrive on the system clock and the host writes
// one configuration word per strobe.
// What this block does
// - Six independent loops, own settings and state.
// - Error is setpoint minus sampled feedback.
// - PID filter result drives chosen output.
// - Output recomputed once per programmed milliseconds.
// - Errors inside deadband are ignored.
// - Enabled loop output centred at half scale.
// - Host sets ranges before enabling loops.
// - Host selects feedback and control channels.
// - Mode zero: plain input, no counting.
// - Mode one: rising edges, count cleared.
// - Mode minus one: falling edges, count cleared.
// - Status reads one when counting enabled.
// - Counted edges readable by host.
module pid_loop_and_pulse_counter (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic cfg_we_i,
   input wire logic [pid_pkg::LOOP_W-1:0] cfg_loop_i,
   input wire logic [2:0] cfg_sel_i,
   input wire logic [pid_pkg::ACC_W-1:0] cfg_data_i,
   input wire logic [pid_pkg::NUM_LOOPS-1:0] loop_enable_i,
   input wire logic period_we_i,
   input wire logic [pid_pkg::PERIOD_W-1:0] loop_update_period_i,
   input wire logic [pid_pkg::NUM_AIN*pid_pkg::CODE_W-1:0] ain_codes_i,
   input wire logic counter_input_pin_i,
   input wire logic mode_we_i,
   input wire logic [pid_pkg::MODE_W-1:0] edge_counter_mode_i,
   output logic [pid_pkg::NUM_AOUT*pid_pkg::CODE_W-1:0] aout_codes_o,
   output logic [pid_pkg::NUM_AOUT-1:0] aout_we_o,
   output logic counter_pin_level_o,
   output logic edge_counter_enabled_o,
   output logic [pid_pkg::COUNT_W-1:0] edge_count_value_o
);
   localparam int N = pid_pkg::NUM_LOOPS;
   localparam int CW = pid_pkg::CODE_W;
   localparam int AW = pid_pkg::ACC_W;

   //--------------------------------------------------------------
   // Per-loop configuration and state
   //--------------------------------------------------------------
   logic [CW-1:0] loop_setpoint_q [N];
   logic [pid_pkg::GAIN_W-1:0] proportional_gain_q [N];
   logic [pid_pkg::GAIN_W-1:0] integral_gain_q [N];
   logic [pid_pkg::GAIN_W-1:0] derivative_gain_q [N];
   logic [AW-1:0] integrator_clamp_q [N];
   logic [CW-1:0] error_deadband_q [N];
   logic [pid_pkg::CHAN_W-1:0] feedback_input_select_q [N];
   logic [pid_pkg::CHAN_W-1:0] control_output_select_q [N];
   logic signed [AW-1:0] integ_q [N];
   logic signed [CW:0] prev_err_q [N];
   logic [pid_pkg::PERIOD_W-1:0] loop_update_period_q;
   logic [pid_pkg::TICK_W-1:0] tick_cnt_q;
   logic [pid_pkg::PERIOD_W-1:0] ms_cnt_q;
   logic busy_q;
   logic [pid_pkg::LOOP_W-1:0] idx_q;

   // Saturate a wide signed value into a symmetric limit.
   function automatic logic signed [AW-1:0] clamp(input logic signed [AW+1:0] v, input logic [AW-1:0] lim);
      logic signed [AW+1:0] l;
      l = $signed({2'b00, lim});
      if (v > l) clamp = l[AW-1:0];
      else if (v < -l) clamp = AW'(-l);
      else clamp = v[AW-1:0];
   endfunction

   //--------------------------------------------------------------
   // Millisecond tick and period scheduler
   //--------------------------------------------------------------
   wire ms_tick = (tick_cnt_q == pid_pkg::TICK_W'(pid_pkg::TICK_CYCLES - 1));
   wire period_done = ms_tick && (ms_cnt_q + 1'b1 >= loop_update_period_q);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_q <= '0;
         ms_cnt_q <= '0;
         loop_update_period_q <= pid_pkg::PERIOD_RESET;
      end else begin
         if (period_we_i) loop_update_period_q <= loop_update_period_i;
         tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 1'b1;
         if (ms_tick) ms_cnt_q <= period_done ? '0 : ms_cnt_q + 1'b1;
      end
   end

   //--------------------------------------------------------------
   // Shared arithmetic for the loop being serviced
   //--------------------------------------------------------------
   wire [CW-1:0] fb_code = ain_codes_i[feedback_input_select_q[idx_q]*CW +: CW];
   wire signed [CW:0] err_raw = $signed({1'b0, loop_setpoint_q[idx_q]}) - $signed({1'b0, fb_code});
   wire signed [CW:0] band = $signed({1'b0, error_deadband_q[idx_q]});
   wire signed [CW:0] err = (err_raw <= band && err_raw >= -band) ? '0 : err_raw;
   wire signed [AW+1:0] i_prod = err * $signed({1'b0, integral_gain_q[idx_q]});
   wire signed [AW-1:0] integ_d = clamp(integ_q[idx_q] + i_prod, integrator_clamp_q[idx_q]);
   wire signed [AW+1:0] p_prod = err * $signed({1'b0, proportional_gain_q[idx_q]});
   wire signed [AW+1:0] d_prod = (err - prev_err_q[idx_q]) * $signed({1'b0, derivative_gain_q[idx_q]});
   wire signed [AW+1:0] pid_sum = p_prod + d_prod + integ_d;
   wire signed [AW+1:0] out_wide = (pid_sum >>> pid_pkg::GAIN_FRAC) + $signed({1'b0, pid_pkg::MID_CODE});
   wire [CW-1:0] out_code = out_wide < 0 ? '0 :
      (out_wide > $signed({1'b0, pid_pkg::MAX_CODE})) ? pid_pkg::MAX_CODE : out_wide[CW-1:0];
   wire [pid_pkg::CHAN_W-1:0] out_chan = control_output_select_q[idx_q];

   //--------------------------------------------------------------
   // Sequencer: one loop per cycle after each period boundary
   //--------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         idx_q <= '0;
      end else if (period_done) begin
         busy_q <= 1'b1;
         idx_q <= '0;
      end else if (busy_q) begin
         busy_q <= (idx_q != pid_pkg::LOOP_W'(N - 1));
         idx_q <= idx_q + 1'b1;
      end
   end

   // Converter drive; a disabled loop leaves its output untouched.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         aout_codes_o <= '0;
         aout_we_o <= '0;
      end else begin
         aout_we_o <= '0;
         if (busy_q && loop_enable_i[idx_q]) begin
            aout_codes_o[out_chan*CW +: CW] <= out_code;
            aout_we_o[out_chan] <= 1'b1;
         end
      end
   end

   // Loop state and host configuration writes.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < N; i++) begin
            loop_setpoint_q[i] <= '0;
            proportional_gain_q[i] <= '0;
            integral_gain_q[i] <= '0;
            derivative_gain_q[i] <= '0;
            integrator_clamp_q[i] <= '0;
            error_deadband_q[i] <= '0;
            feedback_input_select_q[i] <= '0;
            control_output_select_q[i] <= '0;
            integ_q[i] <= '0;
            prev_err_q[i] <= '0;
         end
      end else begin
         if (busy_q) begin
            if (loop_enable_i[idx_q]) begin
               integ_q[idx_q] <= integ_d;
               prev_err_q[idx_q] <= err;
            end else begin
               integ_q[idx_q] <= '0;
               prev_err_q[idx_q] <= '0;
            end
         end
         if (cfg_we_i && cfg_loop_i < pid_pkg::LOOP_W'(N)) begin
            unique case (cfg_sel_i)
               pid_pkg::SEL_SETPOINT: loop_setpoint_q[cfg_loop_i] <= cfg_data_i[CW-1:0];
               pid_pkg::SEL_KP: proportional_gain_q[cfg_loop_i] <= cfg_data_i[pid_pkg::GAIN_W-1:0];
               pid_pkg::SEL_KI: integral_gain_q[cfg_loop_i] <= cfg_data_i[pid_pkg::GAIN_W-1:0];
               pid_pkg::SEL_KD: derivative_gain_q[cfg_loop_i] <= cfg_data_i[pid_pkg::GAIN_W-1:0];
               pid_pkg::SEL_CLAMP: integrator_clamp_q[cfg_loop_i] <= cfg_data_i;
               pid_pkg::SEL_BAND: error_deadband_q[cfg_loop_i] <= cfg_data_i[CW-1:0];
               pid_pkg::SEL_CHAN: begin
                  feedback_input_select_q[cfg_loop_i] <= cfg_data_i[pid_pkg::CHAN_W-1:0];
                  control_output_select_q[cfg_loop_i] <= cfg_data_i[2*pid_pkg::CHAN_W-1:pid_pkg::CHAN_W];
               end
               default: ;
            endcase
         end
      end
   end

   //--------------------------------------------------------------
   // Edge counter
   //--------------------------------------------------------------
   edge_counter counter_u (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pin_i(counter_input_pin_i),
      .mode_we_i(mode_we_i),
      .mode_i(edge_counter_mode_i),
      .pin_level_o(counter_pin_level_o),
      .enabled_o(edge_counter_enabled_o),
      .count_o(edge_count_value_o)
   );
endmodule

// ---- core/pid_pkg.sv ----
// Constants, widths and enumerations shared by the process loop and edge counter.
// Assumes a single 100 MHz system clock and 12-bit converter codes.
package pid_pkg;
   localparam int NUM_LOOPS = 6;
   localparam int NUM_AIN = 8;
   localparam int NUM_AOUT = 8;
   localparam int CODE_W = 12;
   localparam int CHAN_W = 3;
   localparam int LOOP_W = 3;
   localparam int GAIN_W = 16;
   localparam int GAIN_FRAC = 8;
   localparam int ACC_W = 32;
   localparam int PERIOD_W = 16;
   localparam int COUNT_W = 32;
   localparam int MODE_W = 2;
   localparam int CLOCK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYCLES = CLOCK_HZ / MS_PER_S;
   localparam int TICK_W = 17;
   localparam logic [CODE_W-1:0] MID_CODE = 12'h800;
   localparam logic [CODE_W-1:0] MAX_CODE = 12'hfff;
   localparam logic [PERIOD_W-1:0] PERIOD_RESET = 16'h0019;
   localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
   localparam logic [MODE_W-1:0] MODE_RISE = 2'h1;
   localparam logic [MODE_W-1:0] MODE_FALL = 2'h3;
   typedef enum logic [2:0] {SEL_SETPOINT, SEL_KP, SEL_KI, SEL_KD, SEL_CLAMP, SEL_BAND, SEL_CHAN} cfg_sel_t;
endpackage

// ---- tb/converter_model.sv ----
// Converter model: every input channel reads mid scale, output writes are captured.
// Assumes one write strobe per updated output code.
module converter_model (
   input wire logic clock_i,
   input wire logic [95:0] aout_codes_i,
   input wire logic [7:0] aout_we_i,
   output logic [95:0] ain_codes_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] dac_q [8];
   int writes [8] = '{default: 0};
   // All feedback channels sit at mid scale.
   assign ain_codes_o = {8{12'h800}};
   // Latch each written code and count the writes per channel.
   always @(posedge clock_i) begin
      for (int k = 0; k < 8; k++) begin
         if (aout_we_i[k]) begin
            dac_q[k] <= aout_codes_i[12*k+:12];
            writes[k] <= writes[k] + 1;
         end
      end
   end
endmodule

// ---- tb/pid_loop_and_pulse_counter_checker.sv ----
// Port checks for the loop outputs and the edge counter.
// Assumes one clock domain with rst_i as its asynchronous reset.
module pid_loop_and_pulse_counter_checker (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic counter_input_pin_i,
   input wire logic mode_we_i,
   input wire logic [pid_pkg::MODE_W-1:0] edge_counter_mode_i,
   input wire logic [pid_pkg::NUM_AOUT*pid_pkg::CODE_W-1:0] aout_codes_o,
   input wire logic [pid_pkg::NUM_AOUT-1:0] aout_we_o,
   input wire logic counter_pin_level_o,
   input wire logic edge_counter_enabled_o,
   input wire logic [pid_pkg::COUNT_W-1:0] edge_count_value_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // A mode write that turns counting on, and a pin held for four edges.
   sequence mode_on_write;
      mode_we_i && (edge_counter_mode_i == pid_pkg::MODE_RISE || edge_counter_mode_i == pid_pkg::MODE_FALL);
   endsequence
   sequence pin_settled;
      $stable(counter_input_pin_i) [*4];
   endsequence
   a_we_one_cycle: assert property (aout_we_o != '0 |=> (aout_we_o & $past(aout_we_o)) == '0)
      else $error("output strobe longer than one cycle");
   a_code_needs_we: assert property (!$stable(aout_codes_o) |-> aout_we_o != '0)
      else $error("output code changed without strobe");
   a_mode_on_status: assert property (mode_on_write |=> edge_counter_enabled_o)
      else $error("status not set by counting mode");
   a_mode_off_status: assert property (mode_we_i && edge_counter_mode_i == pid_pkg::MODE_OFF |=> !edge_counter_enabled_o)
      else $error("status not cleared by mode zero");
   a_mode_clears: assert property (mode_on_write |=> edge_count_value_o == '0)
      else $error("count not cleared by mode write");
   a_off_holds: assert property (!edge_counter_enabled_o && !mode_we_i |=> $stable(edge_count_value_o))
      else $error("count moved while disabled");
   a_count_step: assert property (!mode_we_i |=> edge_count_value_o - $past(edge_count_value_o) <= 32'h1)
      else $error("count jumped");
   a_pin_follows: assert property (pin_settled |-> counter_pin_level_o == counter_input_pin_i)
      else $error("pin level not followed");
endmodule

bind pid_loop_and_pulse_counter pid_loop_and_pulse_counter_checker chk (.clock_i(clock_i), .rst_i(rst_i),
   .counter_input_pin_i(counter_input_pin_i), .mode_we_i(mode_we_i), .edge_counter_mode_i(edge_counter_mode_i),
   .aout_codes_o(aout_codes_o), .aout_we_o(aout_we_o), .counter_pin_level_o(counter_pin_level_o),
   .edge_counter_enabled_o(edge_counter_enabled_o), .edge_count_value_o(edge_count_value_o));

// ---- tb/pid_loop_and_pulse_counter_tb.sv ----
// Bench: edge counter modes, then one loop update with four loops set up.
// Assumes converter_model and the bound checker.
module pid_loop_and_pulse_counter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i, rst_i, cfg_we, period_we, pin, mode_we, lvl, on;
   logic [2:0] cfg_loop, cfg_sel;
   logic [31:0] cfg_data, cnt;
   logic [5:0] loop_en;
   logic [15:0] period;
   logic [1:0] mode;
   logic [95:0] ain, aout;
   logic [7:0] we;
   int mismatches = 0;
   int cmp_count = 0;
   // Design and converter model.
   pid_loop_and_pulse_counter uut (.clock_i(clock_i), .rst_i(rst_i), .cfg_we_i(cfg_we), .cfg_loop_i(cfg_loop),
      .cfg_sel_i(cfg_sel), .cfg_data_i(cfg_data), .loop_enable_i(loop_en), .period_we_i(period_we),
      .loop_update_period_i(period), .ain_codes_i(ain), .counter_input_pin_i(pin), .mode_we_i(mode_we),
      .edge_counter_mode_i(mode), .aout_codes_o(aout), .aout_we_o(we), .counter_pin_level_o(lvl),
      .edge_counter_enabled_o(on), .edge_count_value_o(cnt));
   converter_model conv (.clock_i(clock_i), .aout_codes_i(aout), .aout_we_i(we), .ain_codes_o(ain));
   // Compares one value and reports a difference.
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // One-cycle strobes for a configuration word and a counter mode.
   task automatic cfg(input logic [2:0] lp, input logic [2:0] sel, input logic [31:0] d);
      idle(1);
      cfg_loop = lp;
      cfg_sel = sel;
      cfg_data = d;
      cfg_we = 1'b1;
      idle(1);
      cfg_we = 1'b0;
   endtask
   task automatic set_mode(input logic [1:0] m);
      idle(1);
      mode = m;
      mode_we = 1'b1;
      idle(1);
      mode_we = 1'b0;
   endtask
   // Gives n full pin periods, well slower than the synchroniser.
   task automatic pulses(input int n);
      repeat (2 * n) begin
         idle(6);
         pin = ~pin;
      end
      idle(6);
   endtask
   // --------------------
   // Scenarios
   // --------------------
   // Counter off, rising, falling, unused code, off again.
   task automatic counter_test;
      pulses(2);
      check(cnt, 32'h0);
      check(32'(on), 32'h0);
      pin = 1'b1;
      idle(6);
      check(32'(lvl), 32'h1);
      set_mode(2'h1);
      check(cnt, 32'h0);
      check(32'(on), 32'h1);
      pulses(3);
      check(cnt, 32'h3);
      set_mode(2'h3);
      check(cnt, 32'h0);
      check(32'(on), 32'h1);
      pulses(2);
      check(cnt, 32'h2);
      set_mode(2'h2);
      check(32'(on), 32'h0);
      set_mode(2'h0);
      check(32'(on), 32'h0);
   endtask
   // Loop 0 plain with derivative, loop 1 at deadband edge, loop 2 clamped, loop 3 disabled.
   task automatic loop_test;
      int n;
      cfg(3'h0, 3'h0, 32'h900);
      cfg(3'h0, 3'h1, 32'h100);
      cfg(3'h0, 3'h3, 32'h80);
      cfg(3'h1, 3'h0, 32'h810);
      cfg(3'h1, 3'h1, 32'h100);
      cfg(3'h1, 3'h5, 32'h10);
      cfg(3'h1, 3'h6, 32'h9);
      cfg(3'h2, 3'h0, 32'ha00);
      cfg(3'h2, 3'h2, 32'h100);
      cfg(3'h2, 3'h4, 32'h1000);
      cfg(3'h2, 3'h6, 32'h12);
      cfg(3'h3, 3'h6, 32'h1b);
      period = 16'h1;
      period_we = 1'b1;
      idle(1);
      period_we = 1'b0;
      loop_en = 6'h07;
      n = 0;
      while (we[0] !== 1'b1 && n < 110000) begin
         idle(1);
         n++;
      end
      check(32'(n < 110000), 32'h1);
      idle(10);
      check(32'(aout[11:0]), 32'h980);
      check(32'(conv.dac_q[1]), 32'h800);
      check(32'(conv.dac_q[2]), 32'h810);
      check(32'(aout[47:36]), 32'h0);
      for (int k = 0; k < 4; k++) check(32'(conv.writes[k]), k < 3 ? 32'h1 : 32'h0);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Clock, then reset for three cycles and the scenarios.
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      {rst_i, cfg_we, period_we, pin, mode_we} = 5'h10;
      {cfg_loop, cfg_sel, mode, loop_en} = '0;
      cfg_data = '0;
      period = 16'h19;
      repeat (3) @(posedge clock_i);
      idle(1);
      rst_i = 1'b0;
      counter_test;
      loop_test;
      final_report;
   end
   // The first loop update lands one millisecond after reset, near 100000 cycles; well past that means a hang.
   initial begin
      repeat (150000) @(posedge clock_i);
      mismatches++;
      final_report;
   end
endmodule
